// >>> src/ncdp_core.sv
// nibble cpu datapath: data memory, table pointer, accumulator, alu, flags
// Notes on behaviour
// - data memory holds 32 words of 4 bits each
// - memory words readable and writable singly or as 8-bit high/low pairs
// - reset clears pair zero to 00H, other words keep their contents
// - pair zero supplies low part of the table-read pointer
// - last pair doubles as storage of the saved return address
// - pointer is control bits 5:4 above the 8 bits of pair zero
// - table reference fetches program word at the pointer
// - pointer reads 000H after reset
// - 4-bit accumulator, not initialised by reset
// - 4-bit alu, mostly logical operations
// - status test sets flag when selected condition holds
// - status test clears flag when selected condition fails
// - leaving standby sets the flag
// - halt with wake condition true sets flag, no standby
// - halt with flag set and no wake clears flag, no standby
// - test patterns 000, 011, 110 true when any key input is high
// - test pattern 101 true when timer down counter is zero
// - operand bit 3 ORs in either side input being high
// - and/xor set carry to acc bit3 AND operand bit3
// - rotates load carry with acc bit 3 before rotation
// - increment and carry probe set carry when acc was 0FH
// - or, transfer and port read clear carry
//
// Design decisions made here: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
module ncdp_core (
  // apb slave
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // pins
  input  wire logic [3:0]  key_input_pins,
  input  wire logic        side_input_zero,
  input  wire logic        side_input_one,
  // neighbouring cpu logic
  input  wire logic        timer_zero,
  input  wire logic        wake_condition,
  input  wire logic        standby_exit,
  output logic             standby_req,
  // program memory
  output logic      [9:0]  table_read_pointer,
  input  wire logic [9:0]  rom_data
);
  import ncdp_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic [5:0] pin_raw;
  logic [5:0] pin_s1;
  logic [5:0] pin_s2;
  logic [5:0] pin_s3;
  logic [5:0] pin_flt;
  logic [3:0] keys;
  logic       side_any;

  assign pin_raw = {side_input_one, side_input_zero, key_input_pins};

  genvar gi;
  for (gi = 0; gi < 6; gi++)
  begin : g_sync
    // a change counts only once the last two stages agree
    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
        {pin_s1[gi], pin_s2[gi], pin_s3[gi], pin_flt[gi]} <= 4'h0;
      else
      begin
        pin_s1[gi] <= pin_raw[gi];
        pin_s2[gi] <= pin_s1[gi];
        pin_s3[gi] <= pin_s2[gi];
        if (pin_s2[gi] == pin_s3[gi])
          pin_flt[gi] <= pin_s3[gi];
      end
    end
  end

  assign keys     = pin_flt[3:0];
  assign side_any = pin_flt[4] | pin_flt[5];

  ////////////////////////////////////////////////////////////////////////
  // apb decode and handshake
  ncdp_apb_type    apb_state;
  ncdp_apb_type    next_apb_state;
  logic [31:0]     next_prdata;
  logic            next_pready;
  logic            next_pslverr;
  logic            word_hit;
  logic            pair_hit;
  logic            reg_hit;
  logic            addr_ok;
  logic            wr_go;
  logic [4:0]      rd_addr;
  logic [4:0]      word_idx;
  logic [3:0]      pair_idx;
  logic [7:0]      rd_data;
  logic [7:0]      pair_zero;
  ncdp_ramreq_type ram_wr;

  logic [5:0]      ctrl0;
  logic [3:0]      acc;
  logic            carry_bit;
  logic            status_flag;
  logic            tbl_busy;
  logic [9:0]      tbl_data;
  logic [1:0]      stack_hi;

  always_comb
  begin
    word_hit = (paddr >= RAM_WORD_BASE) && (paddr < RAM_PAIR_BASE);
    pair_hit = (paddr >= RAM_PAIR_BASE);
    word_idx = 5'((paddr - RAM_WORD_BASE) >> 2);
    pair_idx = 4'((paddr - RAM_PAIR_BASE) >> 2);
    reg_hit  = (paddr == ADDR_CTRL0) || (paddr == ADDR_STATUS) || (paddr == ADDR_CMD)
            || (paddr == ADDR_TABLE) || (paddr == ADDR_STACK);
    addr_ok  = (paddr[1:0] == 2'h0) && (reg_hit || word_hit || pair_hit);
    if (word_hit)
      rd_addr = word_idx;
    else if (pair_hit)
      rd_addr = {1'h0, pair_idx};
    else
      rd_addr = {1'h0, PAIR_LAST};
    // write lands at the edge where the master sees pready high
    wr_go = (apb_state == APB_DONE) && psel && penable && pwrite && addr_ok;
  end

  always_comb
  begin
    next_apb_state = apb_state;
    next_prdata    = prdata;
    next_pready    = 1'h0;
    next_pslverr   = 1'h0;
    unique case (apb_state)
      APB_IDLE:
        if (psel && penable)
          next_apb_state = APB_WAIT;
      APB_WAIT:
      begin
        // memory read data is one cycle old here, hence the wait state
        next_apb_state = APB_DONE;
        next_pready    = 1'h1;
        next_pslverr   = !addr_ok;
        next_prdata    = 32'h0;
        if (addr_ok && !pwrite)
        begin
          if (word_hit)
            next_prdata = {28'h0, rd_data[3:0]};
          else if (pair_hit)
            next_prdata = {24'h0, rd_data};
          else if (paddr == ADDR_CTRL0)
            next_prdata = {26'h0, ctrl0};
          else if (paddr == ADDR_STATUS)
            next_prdata = {25'h0, tbl_busy, status_flag, carry_bit, acc};
          else if (paddr == ADDR_TABLE)
            next_prdata = {22'h0, tbl_data};
          else if (paddr == ADDR_STACK)
            next_prdata = {22'h0, stack_hi, rd_data};
        end
      end
      APB_DONE: next_apb_state = APB_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      apb_state <= APB_IDLE;
      prdata    <= 32'h0;
      pready    <= 1'h0;
      pslverr   <= 1'h0;
    end
    else
    begin
      apb_state <= next_apb_state;
      prdata    <= next_prdata;
      pready    <= next_pready;
      pslverr   <= next_pslverr;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // command execution: alu, flags, table and stack
  ncdp_cmd_type cmd;
  ncdp_op_type  op;
  logic         cmd_go;
  logic         test_true;
  logic [3:0]   operand;
  logic [5:0]   next_ctrl0;
  logic [3:0]   next_acc;
  logic         next_carry;
  logic         next_flag;
  logic         next_standby;
  logic         next_tbl_busy;
  logic [9:0]   next_tbl_data;
  logic [9:0]   next_pointer;
  logic [1:0]   next_stack_hi;

  assign cmd     = ncdp_cmd_type'(pwdata[17:0]);
  assign op      = ncdp_op_type'(cmd.opcode);
  assign operand = cmd.operand;
  assign cmd_go  = wr_go && (paddr == ADDR_CMD);

  always_comb
  begin
    unique case (operand[2:0])
      TEST_KEY_A, TEST_KEY_B, TEST_KEY_C:
        test_true = |keys;
      TEST_TIMER:
        test_true = timer_zero;
      default:
        test_true = 1'h0;
    endcase
    if (operand[3])
      test_true = test_true | side_any;
  end

  always_comb
  begin
    next_ctrl0    = ctrl0;
    next_acc      = acc;
    next_carry    = carry_bit;
    next_flag     = status_flag;
    next_standby  = 1'h0;
    next_tbl_busy = 1'h0;
    next_tbl_data = tbl_data;
    next_stack_hi = stack_hi;
    next_pointer  = {ctrl0[CTRL0_PTR_LSB +: 2], pair_zero};
    ram_wr        = '0;
    if (wr_go && paddr == ADDR_CTRL0)
      next_ctrl0 = pwdata[5:0];
    if (wr_go && (word_hit || pair_hit))
      ram_wr = '{en: 1'h1, pair: pair_hit, addr: rd_addr, data: pwdata[7:0]};
    // rom is read asynchronously; data settle the cycle after the request
    if (tbl_busy)
      next_tbl_data = rom_data;
    if (cmd_go)
    begin
      // a 4-bit alu; logic ops lead, arithmetic is only increment
      unique case (op)
        OP_AND:     {next_carry, next_acc} = {acc[3] & operand[3], acc & operand};
        OP_XOR:     {next_carry, next_acc} = {acc[3] & operand[3], acc ^ operand};
        OP_OR:      {next_carry, next_acc} = {1'h0, acc | operand};
        OP_ROTL:    {next_carry, next_acc} = {acc[3], acc[2:0], acc[3]};
        OP_ROTLZ:   {next_carry, next_acc} = {acc[3], acc[2:0], 1'h0};
        OP_INC:     {next_carry, next_acc} = {acc == ACC_FULL, 4'(acc + 4'h1)};
        OP_CPADD:   next_carry = (acc == ACC_FULL);
        OP_XFER:    {next_carry, next_acc} = {1'h0, operand};
        OP_PORT_RD: {next_carry, next_acc} = {1'h0, keys};
        OP_STATUS_TEST_OP:    next_flag = test_true;
        OP_HALT:
          if (wake_condition)
            next_flag = 1'h1;
          else if (status_flag)
            next_flag = 1'h0;
          else
            next_standby = 1'h1;
        OP_TABLE:   next_tbl_busy = 1'h1;
        OP_PUSH:
        begin
          ram_wr        = '{en: 1'h1, pair: 1'h1, addr: {1'h0, PAIR_LAST},
                            data: cmd.ret_addr[7:0]};
          next_stack_hi = cmd.ret_addr[9:8];
        end
        default:    next_acc = acc;
      endcase
    end
    // set wins over any clear in the same cycle
    if (standby_exit)
      next_flag = 1'h1;
  end

  ncdp_ram u_ram (
    .pclk      (pclk),
    .presetn   (presetn),
    .wr        (ram_wr),
    .rd_addr   (rd_addr),
    .rd_pair   (!word_hit),
    .rd_data   (rd_data),
    .pair_zero (pair_zero)
  );

  // accumulator and upper stack bits are deliberately left unreset
  always_ff @(posedge pclk)
  begin
    acc      <= next_acc;
    stack_hi <= next_stack_hi;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl0              <= CTRL0_RESET;
      carry_bit          <= 1'h0;
      status_flag        <= 1'h0;
      standby_req        <= 1'h0;
      tbl_busy           <= 1'h0;
      tbl_data           <= 10'h000;
      table_read_pointer <= POINTER_RESET;
    end
    else
    begin
      ctrl0              <= next_ctrl0;
      carry_bit          <= next_carry;
      status_flag        <= next_flag;
      standby_req        <= next_standby;
      tbl_busy           <= next_tbl_busy;
      tbl_data           <= next_tbl_data;
      table_read_pointer <= next_pointer;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_LOGIC_CARRY: assert property (
    cmd_go && (op == OP_AND || op == OP_XOR) |=> carry_bit == ($past(acc[3]) & $past(operand[3])))
    else $error("carry wrong after and/xor");
  AST_ROT_CARRY: assert property (
    cmd_go && (op == OP_ROTL || op == OP_ROTLZ) |=> carry_bit == $past(acc[3]) && acc[0] == ($past(op) == OP_ROTL ? $past(acc[3]) : 1'h0))
    else $error("rotate carry or data wrong");
  AST_INC_CARRY: assert property (
    cmd_go && (op == OP_INC || op == OP_CPADD) |=> carry_bit == ($past(acc) == ACC_FULL))
    else $error("increment carry wrong");
  AST_CARRY_CLEAR: assert property (
    cmd_go && (op == OP_OR || op == OP_XFER || op == OP_PORT_RD) |=> !carry_bit)
    else $error("carry not cleared");
  AST_TEST_FLAG: assert property (
    cmd_go && op == OP_STATUS_TEST_OP && !standby_exit |=> status_flag == $past(test_true))
    else $error("status test flag wrong");
  AST_EXIT_FLAG: assert property (
    standby_exit |=> status_flag)
    else $error("flag not set on standby exit");
  AST_HALT_WAKE: assert property (
    cmd_go && op == OP_HALT && wake_condition |=> status_flag && !standby_req)
    else $error("halt with wake misbehaved");
  AST_HALT_CLEAR: assert property (
    cmd_go && op == OP_HALT && !wake_condition && status_flag && !standby_exit
      |=> !status_flag && !standby_req)
    else $error("halt did not clear flag");
  AST_POINTER: assert property (
    ##1 table_read_pointer == {$past(ctrl0[5:4]), $past(pair_zero)})
    else $error("pointer not formed from ctrl and pair zero");
  AST_PREADY: assert property (
    psel && penable && apb_state == APB_IDLE |=> !pready ##1 pready ##1 !pready)
    else $error("apb answer timing wrong");

  COV_TABLE: cover property (cmd_go && op == OP_TABLE ##2 !tbl_busy);
  COV_STANDBY: cover property (cmd_go && op == OP_HALT ##1 standby_req);
  COV_TEST_TRUE: cover property (cmd_go && op == OP_STATUS_TEST_OP && test_true);
  COV_PAIR_WRITE: cover property (wr_go && pair_hit);

endmodule

// >>> shared/ncdp_pkg.sv
// shared constants and types of the nibble datapath core
package ncdp_pkg;

  // apb byte addresses
  localparam logic [7:0] ADDR_CTRL0     = 8'h00;
  localparam logic [7:0] ADDR_STATUS    = 8'h04;
  localparam logic [7:0] ADDR_CMD       = 8'h08;
  localparam logic [7:0] ADDR_TABLE     = 8'h0C;
  localparam logic [7:0] ADDR_STACK     = 8'h10;
  localparam logic [7:0] RAM_WORD_BASE  = 8'h40;
  localparam logic [7:0] RAM_PAIR_BASE  = 8'hC0;

  // field positions and reset values
  localparam int         CTRL0_PTR_LSB  = 4;
  localparam logic [5:0] CTRL0_RESET    = 6'h03;
  localparam logic [7:0] PAIR_ZERO_RST  = 8'h00;
  localparam logic [9:0] POINTER_RESET  = 10'h000;
  localparam logic [3:0] PAIR_ZERO      = 4'h0;
  localparam logic [3:0] PAIR_LAST      = 4'hF;
  localparam logic [3:0] ACC_FULL       = 4'hF;

  // status-test operand low patterns
  localparam logic [2:0] TEST_KEY_A     = 3'h0;
  localparam logic [2:0] TEST_KEY_B     = 3'h3;
  localparam logic [2:0] TEST_KEY_C     = 3'h6;
  localparam logic [2:0] TEST_TIMER     = 3'h5;

  typedef enum logic [3:0] {
    OP_AND, OP_XOR, OP_OR, OP_ROTL, OP_ROTLZ, OP_INC, OP_CPADD,
    OP_XFER, OP_PORT_RD, OP_STATUS_TEST_OP, OP_HALT, OP_TABLE, OP_PUSH
  } ncdp_op_type;

  typedef enum {APB_IDLE, APB_WAIT, APB_DONE} ncdp_apb_type;

  typedef struct packed {
    logic [9:0] ret_addr;
    logic [3:0] operand;
    logic [3:0] opcode;
  } ncdp_cmd_type;

  typedef struct packed {
    logic       en;
    logic       pair;
    logic [4:0] addr;
    logic [7:0] data;
  } ncdp_ramreq_type;

endpackage

// >>> src/ncdp_ram.sv
// 32 x 4 data memory with single and pair access
`timescale 1ns/1ps
module ncdp_ram (
  // clock and reset
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  // write side
  input  wire ncdp_pkg::ncdp_ramreq_type wr,
  // read side
  input  wire logic [4:0]              rd_addr,
  input  wire logic                    rd_pair,
  output logic      [7:0]              rd_data,
  output logic      [7:0]              pair_zero
);
  import ncdp_pkg::*;

  // pair zero lives in flops so it can be cleared; the rest keeps data
  logic [3:0] mem [0:31];
  logic [7:0] next_pair_zero;
  logic [3:0] lo_word;
  logic [3:0] hi_word;
  logic [7:0] next_rd_data;

  always_comb
  begin
    next_pair_zero = pair_zero;
    if (wr.en && wr.addr[3:0] == PAIR_ZERO)
    begin
      if (wr.pair)
        next_pair_zero = wr.data;
      else if (wr.addr[4])
        next_pair_zero[7:4] = wr.data[3:0];
      else
        next_pair_zero[3:0] = wr.data[3:0];
    end
    lo_word = (rd_addr[3:0] == PAIR_ZERO) ? pair_zero[3:0] : mem[{1'h0, rd_addr[3:0]}];
    hi_word = (rd_addr[3:0] == PAIR_ZERO) ? pair_zero[7:4] : mem[{1'h1, rd_addr[3:0]}];
    next_rd_data = rd_pair ? {hi_word, lo_word}
                           : {4'h0, (rd_addr[4] ? hi_word : lo_word)};
  end

  // no reset on the array: contents survive a reset
  always_ff @(posedge pclk)
  begin
    if (wr.en && wr.pair)
    begin
      mem[{1'h0, wr.addr[3:0]}] <= wr.data[3:0];
      mem[{1'h1, wr.addr[3:0]}] <= wr.data[7:4];
    end
    else if (wr.en)
      mem[wr.addr] <= wr.data[3:0];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pair_zero <= PAIR_ZERO_RST;
      rd_data   <= 8'h00;
    end
    else
    begin
      pair_zero <= next_pair_zero;
      rd_data   <= next_rd_data;
    end
  end

endmodule

// >>> test/test_nibble_cpu_datapath_flags.sv
// self-checking bench of the nibble datapath core
`timescale 1ns/1ps
module test_nibble_cpu_datapath_flags;
  import ncdp_pkg::*;
  ////////////////////////////////////////////////////////////////////////////////
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  keys, a, b;
  logic        side0, side1, tz, wake, sexit, sreq, c;
  logic [9:0]  tptr, rom, r;
  logic [7:0]  pv;
  logic [3:0]  mem [32];
  logic [4:0]  e;
  int          n_fail, n_tests, cyc, n_stby, s0, i, j;
  ncdp_op_type ops [8] = '{OP_AND, OP_XOR, OP_OR, OP_ROTL, OP_ROTLZ, OP_INC, OP_CPADD, OP_XFER};

  ncdp_core u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .key_input_pins(keys), .side_input_zero(side0), .side_input_one(side1),
    .timer_zero(tz), .wake_condition(wake), .standby_exit(sexit), .standby_req(sreq),
    .table_read_pointer(tptr), .rom_data(rom)
  );

  always #10 pclk = ~pclk;

  // hang guard; whole run is a few thousand cycles
  always @(posedge pclk)
  begin
    cyc++;
    if (sreq === 1'b1)
      n_stby++;
    if (cyc == 20000)
    begin
      n_fail++;
      test_done();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  // request held until pready is seen high at an edge
  task automatic apb(input logic wr, input logic [7:0] ad, input logic [31:0] wd);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= ad;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic cmd(input ncdp_op_type op, input logic [3:0] opd, input logic [9:0] ra);
    apb(1'b1, ADDR_CMD, {14'h0, ra, opd, 4'(op)});
  endtask

  task automatic settle;
    repeat (8) @(posedge pclk);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [4:0] alu_exp(input ncdp_op_type op, input logic [3:0] x,
                                         input logic [3:0] y);
    case (op)
      OP_AND:   return {x[3] & y[3], x & y};
      OP_XOR:   return {x[3] & y[3], x ^ y};
      OP_OR:    return {1'b0, x | y};
      OP_ROTL:  return {x[3], x[2:0], x[3]};
      OP_ROTLZ: return {x[3], x[2:0], 1'b0};
      OP_INC:   return {x == ACC_FULL, x + 4'h1};
      OP_CPADD: return {x == ACC_FULL, x};
      default:  return {1'b0, y};
    endcase
  endfunction

  function automatic logic cond(input logic [3:0] o, input logic [3:0] k, input logic t,
                                input logic z0, input logic z1);
    logic v;
    v = 1'b0;
    if (o[2:0] == TEST_KEY_A || o[2:0] == TEST_KEY_B || o[2:0] == TEST_KEY_C)
      v = |k;
    if (o[2:0] == TEST_TIMER)
      v = t;
    return v | (o[3] & (z0 | z1));
  endfunction
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
    keys = 0; side0 = 0; side1 = 0; tz = 0; wake = 0; sexit = 0; rom = 0;
    n_fail = 0; n_tests = 0; cyc = 0; n_stby = 0;
    rd = $urandom(32'h1EC84E95);
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    // reset state, then a second reset in mid-run
    apb(1'b0, RAM_PAIR_BASE, 0);
    chk("pair0", 32'(PAIR_ZERO_RST), rd);
    chk("pointer", 32'(POINTER_RESET), 32'(tptr));
    apb(1'b1, RAM_PAIR_BASE, 32'h5A);
    apb(1'b1, RAM_PAIR_BASE + 8'h14, 32'hC3);
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    chk("pointer", 32'(POINTER_RESET), 32'(tptr));
    apb(1'b0, RAM_PAIR_BASE, 0);
    chk("pair0", 32'h0, rd);
    apb(1'b0, RAM_PAIR_BASE + 8'h14, 0);
    chk("pair5", 32'hC3, rd);
    $display("test reset done");
    // every word singly, then as pairs
    for (i = 0; i < 32; i++)
    begin
      mem[i] = 4'($urandom);
      apb(1'b1, RAM_WORD_BASE + 8'(i * 4), {28'h0, mem[i]});
    end
    for (i = 0; i < 32; i++)
    begin
      apb(1'b0, RAM_WORD_BASE + 8'(i * 4), 0);
      chk("word", {28'h0, mem[i]}, rd);
    end
    for (i = 0; i < 16; i++)
    begin
      apb(1'b0, RAM_PAIR_BASE + 8'(i * 4), 0);
      chk("pair", {24'h0, mem[i + 16], mem[i]}, rd);
      pv = 8'($urandom);
      apb(1'b1, RAM_PAIR_BASE + 8'(i * 4), {24'h0, pv});
      apb(1'b0, RAM_WORD_BASE + 8'(i * 4 + 64), 0);
      chk("high word", {28'h0, pv[7:4]}, rd);
      apb(1'b0, RAM_WORD_BASE + 8'(i * 4), 0);
      chk("low word", {28'h0, pv[3:0]}, rd);
    end
    apb(1'b0, 8'h14, 0);
    chk("unmapped err", 32'h1, {31'h0, err});
    apb(1'b0, RAM_WORD_BASE + 8'h01, 0);
    chk("unaligned err", 32'h1, {31'h0, err});
    $display("test memory done");
    // pointer from pair zero and control bits, then table fetch
    for (i = 0; i < 8; i++)
    begin
      pv = (i == 0) ? 8'hFF : 8'($urandom);
      s0 = (i == 0) ? 3 : int'($urandom % 4);
      apb(1'b1, ADDR_CTRL0, 32'({2'(s0), 4'($urandom)}));
      apb(1'b1, RAM_PAIR_BASE, {24'h0, pv});
      repeat (2) @(posedge pclk);
      chk("pointer", {22'h0, 2'(s0), pv}, 32'(tptr));
      rom <= 10'($urandom);
      r = rom;
      @(posedge pclk);
      r = rom;
      cmd(OP_TABLE, 4'h0, 10'h0);
      repeat (2) @(posedge pclk);
      apb(1'b0, ADDR_TABLE, 0);
      chk("table word", {22'h0, r}, rd);
    end
    $display("test pointer done");
    // alu ops with carry preset by a probe add
    for (i = 0; i < 8; i++)
      for (j = 0; j < 6; j++)
      begin
        a = (j == 0) ? 4'hF : 4'($urandom);
        b = (j == 0) ? 4'h8 : 4'($urandom);
        cmd(OP_XFER, a, 10'h0);
        cmd(OP_CPADD, 4'h0, 10'h0);
        cmd(ops[i], b, 10'h0);
        apb(1'b0, ADDR_STATUS, 0);
        e = alu_exp(ops[i], a, b);
        chk("acc", {28'h0, e[3:0]}, {28'h0, rd[3:0]});
        chk("carry", {31'h0, e[4]}, {31'h0, rd[4]});
      end
    keys <= 4'($urandom);
    settle();
    cmd(OP_XFER, 4'hF, 10'h0);
    cmd(OP_CPADD, 4'h0, 10'h0);
    cmd(OP_PORT_RD, 4'h0, 10'h0);
    apb(1'b0, ADDR_STATUS, 0);
    chk("port read", {27'h0, 1'b0, keys}, {27'h0, rd[4:0]});
    $display("test alu done");
    // status test over every operand
    for (i = 0; i < 32; i++)
    begin
      keys  <= ($urandom % 2) ? 4'($urandom) : 4'h0;
      side0 <= ($urandom % 3 == 0);
      side1 <= ($urandom % 3 == 0);
      tz    <= 1'($urandom);
      settle();
      c = cond(4'(i), keys, tz, side0, side1);
      cmd(OP_STATUS_TEST_OP, 4'(i), 10'h0);
      apb(1'b0, ADDR_STATUS, 0);
      chk("flag", {31'h0, c}, {31'h0, rd[5]});
    end
    $display("test status done");
    // halt in its three cases, then leaving standby
    side0 <= 1'b0;
    side1 <= 1'b0;
    settle();
    cmd(OP_STATUS_TEST_OP, 4'h1, 10'h0);
    wake <= 1'b1;
    s0 = n_stby;
    cmd(OP_HALT, 4'h0, 10'h0);
    apb(1'b0, ADDR_STATUS, 0);
    chk("halt wake flag", 32'h1, {31'h0, rd[5]});
    wake <= 1'b0;
    cmd(OP_HALT, 4'h0, 10'h0);
    apb(1'b0, ADDR_STATUS, 0);
    chk("halt clear flag", 32'h0, {31'h0, rd[5]});
    chk("no standby", s0, n_stby);
    cmd(OP_HALT, 4'h0, 10'h0);
    repeat (3) @(posedge pclk);
    chk("standby", s0 + 1, n_stby);
    sexit <= 1'b1;
    @(posedge pclk);
    sexit <= 1'b0;
    apb(1'b0, ADDR_STATUS, 0);
    chk("exit flag", 32'h1, {31'h0, rd[5]});
    $display("test halt done");
    // return address shares the last pair
    r = 10'($urandom);
    cmd(OP_PUSH, 4'h0, r);
    apb(1'b0, RAM_PAIR_BASE + 8'h3C, 0);
    chk("last pair", {24'h0, r[7:0]}, rd);
    apb(1'b0, ADDR_STACK, 0);
    chk("stack", {22'h0, r}, {22'h0, rd[9:0]});
    apb(1'b1, RAM_PAIR_BASE + 8'h3C, 32'hA5);
    apb(1'b0, ADDR_STACK, 0);
    chk("stack low", 32'hA5, {24'h0, rd[7:0]});
    $display("test stack done");
    test_done();
  end
endmodule
